// >>> verilog/uerr_map.vh
// Register offsets, field masks and reset values for the uncorrectable error block
`ifndef UERR_MAP_VH
`define UERR_MAP_VH
`define OFS_SUPPRESS      12'h108
`define OFS_FATALITY      12'h10C
`define OFS_STATUS        12'h104
`define OFS_POINTER       12'h118
`define OFS_HDR0          12'h11C
`define OFS_HDR1          12'h120
`define OFS_HDR2          12'h124
`define OFS_HDR3          12'h128
`define ERR_BITS_MASK     32'h003FF011
`define SUPPRESS_RESET    32'h00000000
`define FATALITY_RESET    32'h00062011
`define ERR_COUNT         22
`endif

// >>> verilog/uncorrectable_error_mask_severity.v
// Uncorrectable error mask, severity, status, pointer and header capture
// How it works
// - Mask bit 0 blocks training error reporting
// - Mask bit 4 blocks link protocol reporting
// - Mask bit 12 blocks poisoned packet reporting
// - Mask bit 13 blocks flow control reporting
// - Mask bit 14 blocks completion timeout reporting
// - Mask bit 15 blocks completer abort reporting
// - Mask bit 16 blocks unexpected completion reporting
// - Mask bit 17 blocks receiver overflow reporting
// - Mask bit 18 blocks malformed packet reporting
// - Mask bit 19 blocks ECRC error reporting
// - Mask bit 20 blocks unsupported request reporting
// - Severity bit one means fatal, with resets
// - Each error sets sticky status, write-one clears
// - Five-bit sticky pointer holds first error
// - First unmasked error captures four header words
`include "uerr_map.vh"
module uncorrectable_error_mask_severity #(
    parameter ERR_COUNT = `ERR_COUNT
) (
    // APB
    input  wire         pclk,
    input  wire         presetn,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output reg          pready,
    output reg          pslverr,
    // Error events and offending header
    input  wire [31:0]  err_event,
    input  wire [127:0] err_header,
    // Error messages toward the root complex
    output reg          msg_fatal,
    output reg          msg_nonfatal,
    // Header capture strobe
    output reg          hdr_logged
);

    reg  [31:0]  suppress;
    reg  [31:0]  fatality;
    reg  [31:0]  status;
    reg  [4:0]   pointer;
    reg          pointer_valid;
    reg  [127:0] header;
    reg  [31:0]  next_rdata;
    reg          next_err;
    reg  [4:0]   first_pos;
    integer      i;
    reg  [31:0]  reported;
    reg  [31:0]  fatal_hits;
    reg  [31:0]  clear_req;
    reg          any_rep;
    reg          fatal_rep;
    reg          capture_armed;
    reg          next_fatal;
    reg          next_nonfatal;

    wire [31:0] events    = err_event & `ERR_BITS_MASK;
    wire        setup     = psel & ~penable;
    wire        wr_acc    = psel & penable & pwrite & pready;
    wire        legal     = (paddr[1:0] == 2'b00);

    // Lowest numbered reported error wins the first-error pointer
    function [4:0] lowest_bit;
        input [31:0] v;
        integer k;
        begin
            lowest_bit = 5'h00;
            for (k = 31; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    lowest_bit = k[4:0];
                end
            end
        end
    endfunction

    always @* begin
        first_pos = lowest_bit(reported);
    end

    // Accepted write to one register offset
    function wr_to;
        input        acc;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            wr_to = acc && (addr == ofs);
        end
    endfunction

    // Sticky bit update: a new event wins over a write-one clear
    function sticky_bit;
        input old_val;
        input set_req;
        input clr_req;
        begin
            if (set_req) begin
                sticky_bit = 1'b1;
            end else if (clr_req) begin
                sticky_bit = 1'b0;
            end else begin
                sticky_bit = old_val;
            end
        end
    endfunction

    // Masked error types neither log a header nor send a message
    always @* begin
        reported = 32'h00000000;
        // Training error
        if (events[0] && !suppress[0]) begin
            reported[0] = 1'b1;
        end

        // Data link protocol error
        if (events[4] && !suppress[4]) begin
            reported[4] = 1'b1;
        end

        // Poisoned packet
        if (events[12] && !suppress[12]) begin
            reported[12] = 1'b1;
        end

        // Flow control protocol error
        if (events[13] && !suppress[13]) begin
            reported[13] = 1'b1;
        end

        // Completion timeout
        if (events[14] && !suppress[14]) begin
            reported[14] = 1'b1;
        end

        // Completer abort
        if (events[15] && !suppress[15]) begin
            reported[15] = 1'b1;
        end

        // Unexpected completion
        if (events[16] && !suppress[16]) begin
            reported[16] = 1'b1;
        end

        // Receiver overflow
        if (events[17] && !suppress[17]) begin
            reported[17] = 1'b1;
        end

        // Malformed packet
        if (events[18] && !suppress[18]) begin
            reported[18] = 1'b1;
        end

        // ECRC error
        if (events[19] && !suppress[19]) begin
            reported[19] = 1'b1;
        end

        // Unsupported request
        if (events[20] && !suppress[20]) begin
            reported[20] = 1'b1;
        end

        // Access control violation
        if (events[21] && !suppress[21]) begin
            reported[21] = 1'b1;
        end

        any_rep = |reported;
    end

    // Severity of every reported type picks the message kind
    always @* begin
        fatal_hits = 32'h00000000;
        if (reported[0] && fatality[0]) begin
            fatal_hits[0] = 1'b1;
        end

        if (reported[4] && fatality[4]) begin
            fatal_hits[4] = 1'b1;
        end

        if (reported[12] && fatality[12]) begin
            fatal_hits[12] = 1'b1;
        end

        if (reported[13] && fatality[13]) begin
            fatal_hits[13] = 1'b1;
        end

        if (reported[14] && fatality[14]) begin
            fatal_hits[14] = 1'b1;
        end

        if (reported[15] && fatality[15]) begin
            fatal_hits[15] = 1'b1;
        end

        if (reported[16] && fatality[16]) begin
            fatal_hits[16] = 1'b1;
        end

        if (reported[17] && fatality[17]) begin
            fatal_hits[17] = 1'b1;
        end

        if (reported[18] && fatality[18]) begin
            fatal_hits[18] = 1'b1;
        end

        if (reported[19] && fatality[19]) begin
            fatal_hits[19] = 1'b1;
        end

        if (reported[20] && fatality[20]) begin
            fatal_hits[20] = 1'b1;
        end

        if (reported[21] && fatality[21]) begin
            fatal_hits[21] = 1'b1;
        end

        fatal_rep = |fatal_hits;
    end

    // Write-one clear request per status bit
    always @* begin
        clear_req = 32'h00000000;
        if (wr_to(wr_acc, paddr, `OFS_STATUS)) begin
            clear_req = pwdata & `ERR_BITS_MASK;
        end
    end

    // Capture is disarmed while the status bit the pointer names is still set
    always @* begin
        capture_armed = 1'b1;
        if (pointer_valid && status[pointer]) begin
            capture_armed = 1'b0;
        end
    end

    // Exactly one message per cycle with any reported error
    always @* begin
        next_fatal    = 1'b0;
        next_nonfatal = 1'b0;
        if (any_rep) begin
            next_fatal    = fatal_rep;
            next_nonfatal = ~fatal_rep;
        end
    end

    // Read mux and decode of mapped addresses
    always @* begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        if (!legal) begin
            next_err = 1'b1;
        end else begin
            case (paddr)
                `OFS_STATUS:   next_rdata = status;
                `OFS_SUPPRESS: next_rdata = suppress;
                `OFS_FATALITY: next_rdata = fatality;
                `OFS_POINTER:  next_rdata = {27'h0, pointer};
                `OFS_HDR0:     next_rdata = header[31:0];
                `OFS_HDR1:     next_rdata = header[63:32];
                `OFS_HDR2:     next_rdata = header[95:64];
                `OFS_HDR3:     next_rdata = header[127:96];
                default:       next_err = 1'b1;
            endcase
        end
    end

    // APB answer: no wait state, data and error valid with pready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & next_err;
            if (setup && !pwrite) begin
                prdata <= next_rdata;
            end else if (!psel) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Mask and severity registers; reserved bits stay zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suppress <= `SUPPRESS_RESET;
            fatality <= `FATALITY_RESET;
        end else begin
            if (wr_to(wr_acc, paddr, `OFS_SUPPRESS)) begin
                suppress <= pwdata & `ERR_BITS_MASK;
            end
            if (wr_to(wr_acc, paddr, `OFS_FATALITY)) begin
                fatality <= pwdata & `ERR_BITS_MASK;
            end
        end
    end

    // Sticky status: a new event wins over a write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 32'h00000000;
        end else begin
            for (i = 0; i < ERR_COUNT; i = i + 1) begin
                status[i] <= sticky_bit(status[i], events[i], clear_req[i]);
            end
        end
    end

    // First-error pointer and header capture, rearmed when its status bit clears
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pointer       <= 5'h00;
            pointer_valid <= 1'b0;
            header        <= 128'h0;
            hdr_logged    <= 1'b0;
        end else begin
            hdr_logged <= 1'b0;
            if (any_rep && capture_armed) begin
                pointer       <= first_pos;
                pointer_valid <= 1'b1;
                header        <= err_header;
                hdr_logged    <= 1'b1;
            end
        end
    end

    // One-cycle error message pulses chosen by severity
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_fatal    <= 1'b0;
            msg_nonfatal <= 1'b0;
        end else begin
            msg_fatal    <= next_fatal;
            msg_nonfatal <= next_nonfatal;
        end
    end

endmodule

// >>> verif/uerr_asserts.sv
// Checker for the uncorrectable error block
`include "uerr_map.vh"
module uerr_asserts (
    // Bus and error side
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic        msg_fatal, msg_nonfatal, hdr_logged,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, err_event
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] msk;
    wire         hit = |(err_event & ~msk & `ERR_BITS_MASK);
    // Shadow of the suppress register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            msk <= 32'h0;
        else if (psel && penable && pready && pwrite && paddr == `OFS_SUPPRESS)
            msk <= pwdata;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_quiet;
        !msg_fatal && !msg_nonfatal && !hdr_logged;
    endsequence
    chk_ready_next: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    chk_msg_one: assert property (!(msg_fatal && msg_nonfatal))
        else $error("two messages at once");
    chk_msg_sent: assert property (hit |=> msg_fatal || msg_nonfatal)
        else $error("message missing");
    chk_mask_quiet:
        assert property (!hit |=> s_quiet) else $error("masked error reported");
    chk_hdr_cause: assert property (hdr_logged |-> $past(hit))
        else $error("header capture without cause");
endmodule
bind uncorrectable_error_mask_severity uerr_asserts u_chk (.*);

// >>> verif/tb_uncorrectable_error_mask_severity.sv
// Self-checking bench for the uncorrectable error block
`include "uerr_map.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_uncorrectable_error_mask_severity;
    timeunit 1ns;
    timeprecision 1ns;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]  paddr = 0;
    logic [31:0]  pwdata = 0, err_event = 0, prdata, rd;
    logic [127:0] err_header = 0;
    logic         pready, pslverr, msg_fatal, msg_nonfatal, hdr_logged, se;
    int           error_cnt = 0, checked = 0, cyc = 0;
    uncorrectable_error_mask_severity dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .err_event(err_event), .err_header(err_header), .msg_fatal(msg_fatal),
        .msg_nonfatal(msg_nonfatal), .hdr_logged(hdr_logged));
    always #10 pclk = ~pclk;
    always @(posedge pclk) if (++cyc > 3000) begin error_cnt++; report_and_stop(); end
    task report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1;
        @(negedge pclk);
        while (pready !== 1'b1) @(negedge pclk);
        rd = prdata; se = pslverr;
        @(posedge pclk); psel <= 0; penable <= 0;
    endtask
    task ev(input int b, input logic [2:0] e);
        @(posedge pclk); err_event <= 32'h1 << b;
        err_header <= 128'hDDDDDDDD_CCCCCCCC_BBBBBBBB_AAAAAAAA;
        @(posedge pclk); err_event <= 0; #1;
        `CHK("message and capture", e, {msg_fatal, msg_nonfatal, hdr_logged})
    endtask
    task t_reset;
        xfer(0, `OFS_SUPPRESS, 0); `CHK("mask reset", 32'h0, rd)
        xfer(0, `OFS_FATALITY, 0); `CHK("sev reset", 32'h00062011, rd)
    endtask
    task t_capture;
        ev(18, 3'b101);
        xfer(0, `OFS_STATUS, 0); `CHK("status", 32'h00040000, rd)
        xfer(0, `OFS_POINTER, 0); `CHK("pointer", 5'd18, rd[4:0])
        xfer(0, `OFS_HDR0, 0); `CHK("hdr0", 32'hAAAAAAAA, rd)
        xfer(0, `OFS_HDR3, 0); `CHK("hdr3", 32'hDDDDDDDD, rd)
        xfer(1, `OFS_STATUS, 32'h00040000);
        xfer(0, `OFS_STATUS, 0); `CHK("clear", 32'h0, rd)
    endtask
    task t_mask;
        xfer(1, `OFS_SUPPRESS, 32'hFFFFFFFF);
        xfer(0, `OFS_SUPPRESS, 0); `CHK("mask rw", 32'h003FF011, rd)
        for (int i = 0; i < 22; i++) if (32'h003FF011 >> i & 1) ev(i, 3'b000);
        xfer(1, `OFS_SUPPRESS, 0);
        for (int i = 0; i < 22; i++)
            if (32'h003FF011 >> i & 1) ev(i, (32'h00062011 >> i & 1) ? 3'b100 : 3'b010);
    endtask
    task t_write;
        xfer(1, `OFS_FATALITY, 32'hFFFFFFFF);
        xfer(0, `OFS_FATALITY, 0); `CHK("sev rw", 32'h003FF011, rd)
        ev(14, 3'b100);
        xfer(0, 12'h200, 0); `CHK("unmapped", 1'b1, se)
        `CHK("unmapped data", 32'h0, rd)
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_capture();
        t_mask();
        t_write();
        report_and_stop();
    end
endmodule
